// File: atb_pkg.sv
// constants and types shared by the analog trim register bank
package atb_pkg;

  // ==========================================================
  // register offsets on the analog serial register port
  localparam logic [7:0] ATB_ADDR_DLY_REF  = 8'h0f;
  localparam logic [7:0] ATB_ADDR_HB_COPY  = 8'h10;
  localparam logic [7:0] ATB_ADDR_BR_HS    = 8'h11;

  // ==========================================================
  // field positions, lsb of each field
  localparam int ATB_POS_DLY    = 6;
  localparam int ATB_POS_RSVD   = 4;
  localparam int ATB_POS_INTERNAL_CURRENT_REFERENCE   = 0;
  localparam int ATB_POS_HI2    = 6;
  localparam int ATB_POS_MID3   = 3;
  localparam int ATB_POS_LO3    = 0;

  // ==========================================================
  // reset values
  localparam logic [1:0] ATB_RST_DLY   = 2'h0;
  localparam logic [3:0] ATB_RST_INTERNAL_CURRENT_REFERENCE  = 4'h0;
  localparam logic [1:0] ATB_RST_TRIM2 = 2'h0;
  localparam logic [2:0] ATB_RST_TRIM3 = 3'h0;
  localparam logic [7:0] ATB_RD_ZERO   = 8'h00;

  // ==========================================================
  // reserved copy trim code and highest defined reference trim code
  localparam logic [2:0] ATB_COPY_RSVD = 3'h4;
  localparam logic [3:0] ATB_INTERNAL_CURRENT_REFERENCE_MAX  = 4'h8;

  // ==========================================================
  // over-current filter times and their cycle counts
  localparam int ATB_CLK_PERIOD_NS = 50;
  localparam int ATB_DLY00_US      = 950;
  localparam int ATB_DLY01_US      = 536;
  localparam int ATB_DLY10_US      = 234;
  localparam int ATB_DLY11_US      = 78;
  localparam int ATB_DLY00_CYC     = ATB_DLY00_US * 1000 / ATB_CLK_PERIOD_NS;
  localparam int ATB_DLY01_CYC     = ATB_DLY01_US * 1000 / ATB_CLK_PERIOD_NS;
  localparam int ATB_DLY10_CYC     = ATB_DLY10_US * 1000 / ATB_CLK_PERIOD_NS;
  localparam int ATB_DLY11_CYC     = ATB_DLY11_US * 1000 / ATB_CLK_PERIOD_NS;
  localparam int ATB_CNT_W         = 15;

  // ==========================================================
  // over-current filter states
  typedef enum logic [2:0] {
    ATB_F_IDLE   = 3'b001,
    ATB_F_FILTER = 3'b010,
    ATB_F_TRIP   = 3'b100
  } atb_filt_t;

  // whole state of the bank
  typedef struct packed {
    logic [1:0]           dly;
    logic [3:0]           internal_current_reference;
    logic [1:0]           b12_s0;
    logic [2:0]           b34_s1;
    logic [2:0]           b12_s1;
    logic [1:0]           b34_s0;
    logic [2:0]           hs23;
    logic [2:0]           hs1;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 oc_s1;
    logic                 oc_s2;
    logic [ATB_CNT_W-1:0] cnt;
    atb_filt_t            filt;
  } atb_state_t;

endpackage

// File: atb_trim_bank.sv
// analog trim register bank with over-current filter delay select
//
// Contract
// R1: two-bit filter delay field, read/write, selects 950/536/234/78 us filter.
// R2: reset clears the filter delay field, giving the longest delay.
// R3: four-bit write-only reference trim, nine defined codes, cleared on reset.
// R4: software never sets the two reserved bits of the first register.
// R5: second register bits 7:6 trim bridge one-two copy, sense select 0.
// R6: second register bits 5:3 trim bridge three-four copy, sense select 1.
// R7: second register bits 2:0 trim bridge one-two copy, sense select 1.
// R8: third register bits 7:6 trim bridge three-four copy, sense select 0.
// R9: third register bits 5:3 trim high-side two-three copy.
// R10: third register bits 2:0 trim high-side one copy.
// R11: second and third registers read back as all zeros.
// R12: reset clears every copy trim field to zero.
// R13: software rewrites factory trim values after every reset.
// R14: software never writes code 100 into a three-bit copy trim.
// R15: three registers at consecutive addresses, first register lowest.
// R16: first register holds delay at 7:6, reserved 5:4, reference trim 3:0.
`timescale 1ns/1ps
module atb_trim_bank
  import atb_pkg::*;
#(
  parameter int DLY00_CYCLES = ATB_DLY00_CYC,
  parameter int DLY01_CYCLES = ATB_DLY01_CYC,
  parameter int DLY10_CYCLES = ATB_DLY10_CYC,
  parameter int DLY11_CYCLES = ATB_DLY11_CYC
) (
  // clock, reset, clock enable
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  input  wire logic       CE,
  // register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic            REG_RVALID,
  // supply over-current detection
  input  wire logic       OC_RAW,
  output logic            OC_SHUTDOWN,
  // trim fields to the analog blocks
  output logic      [1:0] SUPPLY_OVERCURRENT_FILTER_DELAY,
  output logic      [3:0] CURRENT_REFERENCE_TRIM,
  output logic      [1:0] BRIDGE12_COPY_TRIM_SENSE0,
  output logic      [2:0] BRIDGE34_COPY_TRIM_SENSE1,
  output logic      [2:0] BRIDGE12_COPY_TRIM_SENSE1,
  output logic      [1:0] BRIDGE34_COPY_TRIM_SENSE0,
  output logic      [2:0] HIGHSIDE23_COPY_TRIM,
  output logic      [2:0] HIGHSIDE1_COPY_TRIM,
  // undefined trim code present
  output logic            TRIM_CODE_UNDEFINED
);

  // ==========================================================
  // filter limits, last count before the trip
  localparam logic [ATB_CNT_W-1:0] LIM00 = ATB_CNT_W'(DLY00_CYCLES - 1);
  localparam logic [ATB_CNT_W-1:0] LIM01 = ATB_CNT_W'(DLY01_CYCLES - 1);
  localparam logic [ATB_CNT_W-1:0] LIM10 = ATB_CNT_W'(DLY10_CYCLES - 1);
  localparam logic [ATB_CNT_W-1:0] LIM11 = ATB_CNT_W'(DLY11_CYCLES - 1);

  atb_state_t           st;
  atb_state_t           next_st;
  logic [ATB_CNT_W-1:0] limit;
  logic                 wr_dly_ref;
  logic                 wr_hb_copy;
  logic                 wr_br_hs;

  // ==========================================================
  // helper functions

  // maps the delay code to the last filter count
  function automatic logic [ATB_CNT_W-1:0] delay_limit(input logic [1:0] code);
    logic [ATB_CNT_W-1:0] lim;
    lim = LIM00;
    case (code)
      2'h0: lim = LIM00;
      2'h1: lim = LIM01;
      2'h2: lim = LIM10;
      2'h3: lim = LIM11;
      default: lim = LIM00;
    endcase
    return lim;
  endfunction

  // flags the reserved code of a three-bit copy trim
  function automatic logic copy_rsvd(input logic [2:0] code);
    return code == ATB_COPY_RSVD;
  endfunction

  // ==========================================================
  // address decode for writes
  assign wr_dly_ref = REG_WR && (REG_ADDR == ATB_ADDR_DLY_REF); // R15
  assign wr_hb_copy = REG_WR && (REG_ADDR == ATB_ADDR_HB_COPY); // R15
  assign wr_br_hs   = REG_WR && (REG_ADDR == ATB_ADDR_BR_HS);   // R15
  assign limit      = delay_limit(st.dly);                       // R1

  // ==========================================================
  // next-state logic
  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    // pin synchroniser, first stage read only by the second
    next_st.oc_s1 = OC_RAW;
    next_st.oc_s2 = st.oc_s1;

    // first register, reserved bits are not stored
    if (wr_dly_ref) begin
      next_st.dly  = REG_WDATA[ATB_POS_DLY +: 2];  // R1 R16
      next_st.internal_current_reference = REG_WDATA[ATB_POS_INTERNAL_CURRENT_REFERENCE +: 4]; // R3 R16 R4
    end
    // second register
    if (wr_hb_copy) begin
      next_st.b12_s0 = REG_WDATA[ATB_POS_HI2 +: 2];  // R5
      next_st.b34_s1 = REG_WDATA[ATB_POS_MID3 +: 3]; // R6
      next_st.b12_s1 = REG_WDATA[ATB_POS_LO3 +: 3];  // R7
    end
    // third register
    if (wr_br_hs) begin
      next_st.b34_s0 = REG_WDATA[ATB_POS_HI2 +: 2];  // R8
      next_st.hs23   = REG_WDATA[ATB_POS_MID3 +: 3]; // R9
      next_st.hs1    = REG_WDATA[ATB_POS_LO3 +: 3];  // R10
    end

    // read answer, old value if a write arrives together
    if (REG_RD) begin
      next_st.rvalid = 1'b1;
      case (REG_ADDR)
        ATB_ADDR_DLY_REF: begin
          next_st.rdata = {st.dly, 6'h00}; // R1 R3 R16
        end
        ATB_ADDR_HB_COPY: begin
          next_st.rdata = ATB_RD_ZERO; // R11
        end
        ATB_ADDR_BR_HS: begin
          next_st.rdata = ATB_RD_ZERO; // R11
        end
        default: begin
          next_st.rdata = ATB_RD_ZERO;
        end
      endcase
    end

    // over-current filter
    case (st.filt)
      ATB_F_IDLE: begin
        next_st.cnt = '0;
        if (st.oc_s2) begin
          next_st.filt = ATB_F_FILTER;
        end
      end
      ATB_F_FILTER: begin
        if (!st.oc_s2) begin
          next_st.filt = ATB_F_IDLE;
          next_st.cnt  = '0;
        end else if (st.cnt >= limit) begin
          next_st.filt = ATB_F_TRIP; // R1
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      ATB_F_TRIP: begin
        next_st.cnt = '0;
        if (!st.oc_s2) begin
          next_st.filt = ATB_F_IDLE;
        end
      end
      default: begin
        next_st.filt = ATB_F_IDLE;
        next_st.cnt  = '0;
      end
    endcase
  end

  // ==========================================================
  // state register, frozen while the clock enable is low
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st        <= '0;
      st.dly    <= ATB_RST_DLY;   // R2
      st.internal_current_reference   <= ATB_RST_INTERNAL_CURRENT_REFERENCE;  // R3 R13
      st.b12_s0 <= ATB_RST_TRIM2; // R12
      st.b34_s1 <= ATB_RST_TRIM3; // R12
      st.b12_s1 <= ATB_RST_TRIM3; // R12
      st.b34_s0 <= ATB_RST_TRIM2; // R12
      st.hs23   <= ATB_RST_TRIM3; // R12
      st.hs1    <= ATB_RST_TRIM3; // R12
      st.filt   <= ATB_F_IDLE;
    end else if (CE) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign REG_RDATA                       = st.rdata;
  assign REG_RVALID                      = st.rvalid;
  assign OC_SHUTDOWN                     = (st.filt == ATB_F_TRIP);
  assign SUPPLY_OVERCURRENT_FILTER_DELAY = st.dly;
  assign CURRENT_REFERENCE_TRIM          = st.internal_current_reference;
  assign BRIDGE12_COPY_TRIM_SENSE0       = st.b12_s0;
  assign BRIDGE34_COPY_TRIM_SENSE1       = st.b34_s1;
  assign BRIDGE12_COPY_TRIM_SENSE1       = st.b12_s1;
  assign BRIDGE34_COPY_TRIM_SENSE0       = st.b34_s0;
  assign HIGHSIDE23_COPY_TRIM            = st.hs23;
  assign HIGHSIDE1_COPY_TRIM             = st.hs1;

  // undefined codes left by software show here
  assign TRIM_CODE_UNDEFINED = (st.internal_current_reference > ATB_INTERNAL_CURRENT_REFERENCE_MAX) || copy_rsvd(st.b34_s1)
    || copy_rsvd(st.b12_s1) || copy_rsvd(st.hs23) || copy_rsvd(st.hs1); // R14

  // ==========================================================
  // checks

  sequence s_wr_first;
    CE && REG_WR && REG_ADDR == ATB_ADDR_DLY_REF;
  endsequence

  sequence s_wr_second;
    CE && REG_WR && REG_ADDR == ATB_ADDR_HB_COPY;
  endsequence

  sequence s_wr_third;
    CE && REG_WR && REG_ADDR == ATB_ADDR_BR_HS;
  endsequence

  sequence s_rd_copy;
    CE && REG_RD && (REG_ADDR == ATB_ADDR_HB_COPY || REG_ADDR == ATB_ADDR_BR_HS);
  endsequence

  // write to the first register lands in delay and reference fields
  a_first_write: assert property ( // R1 R3 R16
    @(posedge SYS_CLK) disable iff (!RST_B)
    s_wr_first |=> SUPPLY_OVERCURRENT_FILTER_DELAY == $past(REG_WDATA[7:6])
      && CURRENT_REFERENCE_TRIM == $past(REG_WDATA[3:0]))
    else $error("first trim register write not stored");

  // read of the first register shows only the delay field
  a_first_read: assert property ( // R1 R16
    @(posedge SYS_CLK) disable iff (!RST_B)
    CE && REG_RD && REG_ADDR == ATB_ADDR_DLY_REF |=> REG_RVALID
      && REG_RDATA == {$past(SUPPLY_OVERCURRENT_FILTER_DELAY), 6'h00})
    else $error("first trim register read wrong");

  // second register fields take the written bits
  a_second_write: assert property ( // R5 R6 R7
    @(posedge SYS_CLK) disable iff (!RST_B)
    s_wr_second |=> {BRIDGE12_COPY_TRIM_SENSE0, BRIDGE34_COPY_TRIM_SENSE1,
      BRIDGE12_COPY_TRIM_SENSE1} == $past(REG_WDATA))
    else $error("second trim register write not stored");

  // third register fields take the written bits
  a_third_write: assert property ( // R8 R9 R10
    @(posedge SYS_CLK) disable iff (!RST_B)
    s_wr_third |=> {BRIDGE34_COPY_TRIM_SENSE0, HIGHSIDE23_COPY_TRIM,
      HIGHSIDE1_COPY_TRIM} == $past(REG_WDATA))
    else $error("third trim register write not stored");

  // copy trim registers always read zero
  a_copy_read_zero: assert property ( // R11
    @(posedge SYS_CLK) disable iff (!RST_B)
    s_rd_copy |=> REG_RVALID && REG_RDATA == 8'h00)
    else $error("write-only trim register read nonzero");

  // every field is clear right after reset release
  a_reset_clear: assert property ( // R2 R12
    @(posedge SYS_CLK)
    $rose(RST_B) |-> SUPPLY_OVERCURRENT_FILTER_DELAY == 2'h0
      && CURRENT_REFERENCE_TRIM == 4'h0 && BRIDGE12_COPY_TRIM_SENSE0 == 2'h0
      && BRIDGE34_COPY_TRIM_SENSE1 == 3'h0 && BRIDGE12_COPY_TRIM_SENSE1 == 3'h0
      && BRIDGE34_COPY_TRIM_SENSE0 == 2'h0 && HIGHSIDE23_COPY_TRIM == 3'h0
      && HIGHSIDE1_COPY_TRIM == 3'h0)
    else $error("trim field not cleared by reset");

  // trip only after the selected count has run out
  a_trip_count: assert property ( // R1
    @(posedge SYS_CLK) disable iff (!RST_B)
    $rose(OC_SHUTDOWN) |-> $past(st.cnt) == $past(limit) && $past(st.oc_s2))
    else $error("over-current trip before filter time");

  // shutdown drops three enabled cycles after the pin goes low
  a_trip_release: assert property ( // R1
    @(posedge SYS_CLK) disable iff (!RST_B)
    OC_SHUTDOWN && CE && !OC_RAW ##1 CE [*2] |=> !OC_SHUTDOWN)
    else $error("over-current shutdown held after release");

  // clock enable low freezes all state
  a_ce_freeze: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    !CE |=> $stable(st))
    else $error("state changed with clock enable low");

endmodule

// File: atb_mcu_model.sv
// controller model that drives the trim register port
`timescale 1ns/1ps
module atb_mcu_model
  import atb_pkg::*;
(
  // clock
  input  wire logic       SYS_CLK,
  // register port
  output logic      [7:0] REG_ADDR,
  output logic            REG_WR,
  output logic      [7:0] REG_WDATA,
  output logic            REG_RD,
  input  wire logic [7:0] REG_RDATA,
  input  wire logic       REG_RVALID
);
  // ==========================================================
  // bus tasks
  // quiet port at time zero
  initial begin
    REG_ADDR  = 8'h00;
    REG_WR    = 1'b0;
    REG_WDATA = 8'h00;
    REG_RD    = 1'b0;
  end
  // released address and data lines show the inverse of their last value, strobes go low
  task automatic idle();
    REG_WR    <= 1'b0;
    REG_RD    <= 1'b0;
    REG_ADDR  <= ~REG_ADDR;
    REG_WDATA <= ~REG_WDATA;
  endtask
  // one write, taken at the following edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge SYS_CLK);
    idle();
  endtask
  // one read, answer sampled one cycle after the request is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge SYS_CLK);
    idle();
    @(posedge SYS_CLK);
    d = REG_RDATA;
    v = REG_RVALID;
  endtask
  // factory bytes go out lowest address first, reserved bits kept clear
  task automatic load(input logic [7:0] t1, input logic [7:0] t2, input logic [7:0] t3);
    wr(ATB_ADDR_DLY_REF, t1 & 8'hcf);
    wr(ATB_ADDR_DLY_REF + 8'h01, t2);
    wr(ATB_ADDR_DLY_REF + 8'h02, t3);
  endtask
endmodule

// File: atb_trim_bank_tb.sv
// self-checking bench for the analog trim register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module atb_trim_bank_tb;
  import atb_pkg::*;
  localparam int NCYC [4] = '{20, 16, 12, 8};
  logic        sys_clk;
  logic        rst_b;
  logic        ce;
  logic        oc_raw;
  logic        oc_shutdown;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        trim_undef;
  wire  [21:0] flds;
  int          seed = 48;
  int          fails = 0;
  int          compares = 0;
  // ==========================================================
  // instances
  atb_trim_bank #(.DLY00_CYCLES(20), .DLY01_CYCLES(16), .DLY10_CYCLES(12),
    .DLY11_CYCLES(8)) u_dut (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .CE(ce), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid), .OC_RAW(oc_raw), .OC_SHUTDOWN(oc_shutdown),
    .SUPPLY_OVERCURRENT_FILTER_DELAY(flds[21:20]), .CURRENT_REFERENCE_TRIM(flds[19:16]),
    .BRIDGE12_COPY_TRIM_SENSE0(flds[15:14]), .BRIDGE34_COPY_TRIM_SENSE1(flds[13:11]),
    .BRIDGE12_COPY_TRIM_SENSE1(flds[10:8]), .BRIDGE34_COPY_TRIM_SENSE0(flds[7:6]),
    .HIGHSIDE23_COPY_TRIM(flds[5:3]), .HIGHSIDE1_COPY_TRIM(flds[2:0]),
    .TRIM_CODE_UNDEFINED(trim_undef));
  atb_mcu_model u_mcu (
    .SYS_CLK(sys_clk), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid));
  // ==========================================================
  // helpers
  // field outputs in port order follow the register bit order
  function automatic logic [21:0] exp_flds(input logic [7:0] t1, input logic [7:0] t2,
                                           input logic [7:0] t3);
    return {t1[7:6], t1[3:0], t2, t3};
  endfunction
  // three-bit copy code with the undefined one skipped
  function automatic logic [2:0] code3();
    logic [2:0] c;
    c = 3'($unsigned($random(seed)) % 7);
    return (c >= 3'h4) ? c + 3'h1 : c;
  endfunction
  task automatic summarize();
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #2000000;
    fails++;
    summarize();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] t1, t2, t3, d;
    logic       v;
    int         n;
    rst_b  = 1'b0;
    ce     = 1'b1;
    oc_raw = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    `CHK("reset fields", 22'h0, flds)
    u_mcu.rd(ATB_ADDR_DLY_REF, d, v);
    `CHK("reset read", 8'h00, d)
    // random factory loads, each register read back
    repeat (12) begin
      t1 = {2'($random(seed)), 2'b00, 4'($unsigned($random(seed)) % 9)};
      t2 = {2'($random(seed)), code3(), code3()};
      t3 = {2'($random(seed)), code3(), code3()};
      u_mcu.load(t1, t2, t3);
      // the last write lands at the edge the task returns on, so look half a cycle later
      @(negedge sys_clk);
      `CHK("trim fields", exp_flds(t1, t2, t3), flds)
      `CHK("undefined code", 1'b0, trim_undef)
      for (int a = 0; a < 4; a++) begin
        u_mcu.rd(ATB_ADDR_DLY_REF + 8'(a), d, v);
        `CHK("read data", (a == 0) ? {t1[7:6], 6'h00} : 8'h00, d)
        `CHK("read valid", 1'b1, v)
      end
    end
    // reference code above the nine defined ones raises the flag
    t1 = 8'h09;
    u_mcu.wr(ATB_ADDR_DLY_REF, t1);
    @(negedge sys_clk);
    `CHK("undefined code", 1'b1, trim_undef)
    // unmapped write and clock-gated write leave the fields alone
    u_mcu.wr(8'h12, 8'hff);
    @(posedge sys_clk);
    ce <= 1'b0;
    u_mcu.wr(ATB_ADDR_HB_COPY, ~t2);
    ce <= 1'b1;
    @(negedge sys_clk);
    `CHK("ignored writes", exp_flds(t1, t2, t3), flds)
    // filter time for every delay code
    for (int k = 0; k < 4; k++) begin
      u_mcu.wr(ATB_ADDR_DLY_REF, {2'(k), 6'h00});
      @(posedge sys_clk);
      oc_raw <= 1'b1;
      n = 0;
      while (oc_shutdown !== 1'b1 && n < 100) begin
        @(posedge sys_clk);
        n++;
      end
      `CHK("filter time", 1'b1, n >= NCYC[k] + 2 && n <= NCYC[k] + 5)
      oc_raw <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
    // reset in mid-run clears, then the factory values go back in
    @(posedge sys_clk);
    rst_b <= 1'b0;
    @(posedge sys_clk);
    `CHK("mid reset fields", 22'h0, flds)
    rst_b <= 1'b1;
    u_mcu.load(t1, t2, t3);
    @(negedge sys_clk);
    `CHK("reloaded fields", exp_flds(t1, t2, t3), flds)
    summarize();
  end
endmodule
